// ===== verilog/plai_map.vh
// Register offsets, field positions and reset values for the PLL/alignment IRQ slice
`ifndef PLAI_MAP_VH
`define PLAI_MAP_VH

// Register offsets (12-bit serial-port address space)
`define PLAI_ADDR_W             12
`define PLAI_OFS_PLL_IRQ_EN     12'h01F
`define PLAI_OFS_ALIGN_IRQ_EN   12'h021
`define PLAI_OFS_PLL_STATUS     12'h023
`define PLAI_OFS_ALIGN_STATUS   12'h026

// Field positions in the PLL enable and PLL status registers
`define PLAI_BIT_CONV_UNLOCK    7
`define PLAI_BIT_CONV_LOCKED    6
`define PLAI_BIT_SERIAL_UNLOCK  4
`define PLAI_BIT_SERIAL_LOCKED  3

// Field positions in the alignment enable and alignment status registers
`define PLAI_BIT_ALIGN_ROTATE   2
`define PLAI_BIT_ALIGN_WINDOW   1
`define PLAI_BIT_ALIGN_TRIP     0

// Writable bits of the alignment enable register; bits 6:5 read-only zero
`define PLAI_ALIGN_EN_RW_MASK   8'h9F
// Writable bits of the PLL enable register in this slice
`define PLAI_PLL_EN_RW_MASK     8'hFF

// Reset values
`define PLAI_RST_BYTE           8'h00
`define PLAI_RST_EVENTS         7'h00

`endif

// ===== verilog/plai_irq_status.v
// PLL lock and link-alignment interrupt enable/status slice with IRQ output
`timescale 1ns/1ps
`include "plai_map.vh"

// How it works
// - Rotate enable set latches rotate event and pulls IRQ low; clear shows live.
// - Window enable set latches outside-window event, asserts IRQ; clear shows live.
// - Trip enable set latches trip event, asserts IRQ; clear shows live.
// - Status 0x023 bit 7 is converter PLL unlock, live or rising-edge latched.
// - Status bit 6 is converter PLL locked, live or rising-edge latched.
// - Status bit 4 is serial PLL unlock, live or rising-edge latched.
// - Status bit 3 is serial PLL locked, live or rising-edge latched.
// - Latched bit holds until software writes one there; zero leaves it.
// - PLL status fields and alignment enable fields reset to zero.
// - Alignment enables live in 0x021 bits 2:0; bits 6:5 read-only.
module plai_irq_status (
   input  wire                    clk,
   input  wire                    reset,
   input  wire                    reg_write,
   input  wire                    reg_read,
   input  wire [`PLAI_ADDR_W-1:0] reg_addr,
   input  wire [7:0]              reg_wdata,
   output reg  [7:0]              reg_rdata,
   output reg                     reg_rvalid,
   input  wire                    conv_pll_unlock_in,
   input  wire                    conv_pll_locked_in,
   input  wire                    serial_pll_unlock_in,
   input  wire                    serial_pll_locked_in,
   input  wire                    align_rotate_in,
   input  wire                    align_window_in,
   input  wire                    align_trip_in,
   output reg                     irq_n
);

   // Event vector order: [6] conv unlock, [5] conv locked,
   // [4] serial unlock, [3] serial locked, [2] rotate, [1] window, [0] trip
   localparam NEV = 7;

   // Register map seen from the serial port (byte wide, 12-bit address):
   //   0x01F  PLL interrupt enables; bits 7,6,4,3 used, rest plain storage
   //   0x021  Alignment enables in bits 2:0; bits 6:5 read zero
   //   0x023  PLL status; bits 7,6,4,3 used, 5 and 2:0 read zero
   //   0x026  Alignment status in bits 2:0; bits 7:3 read zero
   // Status bits are write-one-to-clear once latched; a plain write of
   // zero never disturbs them.
   //
   // Latency from pin to status is three edges: two synchroniser stages
   // and the status flop. A pin pulse shorter than one clock may be lost;
   // the lock detectors hold their levels far longer than that.
   //
   // Interrupt output is computed from the next status value, so it
   // falls on the same edge that sets the latched bit and rises on the
   // edge that clears the last one.

   reg  [7:0]     pll_irq_enable;
   reg  [7:0]     align_irq_enable;
   reg  [NEV-1:0] sync_a;
   reg  [NEV-1:0] sync_b;
   reg  [NEV-1:0] live_d;
   reg  [NEV-1:0] stat;
   reg  [NEV-1:0] en_d;
   wire [NEV-1:0] ev_raw;
   wire [NEV-1:0] en_vec;
   wire [NEV-1:0] rise;
   wire [NEV-1:0] clr_vec;
   wire [NEV-1:0] next_stat;
   wire [NEV-1:0] irq_src;
   wire           wr_pll_en;
   wire           wr_align_en;
   wire           wr_pll_stat;
   wire           wr_align_stat;
   wire [7:0]     pll_status_byte;
   wire [7:0]     align_status_byte;

   // Address hit for a write cycle; reads decode in the read-port case
   function hit;
      input [`PLAI_ADDR_W-1:0] addr;
      input [`PLAI_ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Per-bit status update: enabled bits are sticky, others mirror live.
   // A bit only holds if its enable was already on in the previous cycle,
   // so turning an enable on over a high level does not latch it; only a
   // fresh rise can set a sticky bit.
   function [NEV-1:0] stat_update;
      input [NEV-1:0] cur;
      input [NEV-1:0] en;
      input [NEV-1:0] en_old;
      input [NEV-1:0] live;
      input [NEV-1:0] edge_set;
      input [NEV-1:0] clr;
      reg   [NEV-1:0] held;
      begin
         // Set beats clear so an edge in the clearing cycle survives
         held        = cur & en_old & ~clr;
         stat_update = (en & (held | edge_set)) | (~en & live);
      end
   endfunction

   // Raw pin levels gathered in event order
   assign ev_raw = {conv_pll_unlock_in, conv_pll_locked_in,
                    serial_pll_unlock_in, serial_pll_locked_in,
                    align_rotate_in, align_window_in, align_trip_in};

   // Enable bits gathered in event order
   // Bit order matches ev_raw so every vector lines up by position
   assign en_vec = {pll_irq_enable[`PLAI_BIT_CONV_UNLOCK],
                    pll_irq_enable[`PLAI_BIT_CONV_LOCKED],
                    pll_irq_enable[`PLAI_BIT_SERIAL_UNLOCK],
                    pll_irq_enable[`PLAI_BIT_SERIAL_LOCKED],
                    align_irq_enable[`PLAI_BIT_ALIGN_ROTATE],
                    align_irq_enable[`PLAI_BIT_ALIGN_WINDOW],
                    align_irq_enable[`PLAI_BIT_ALIGN_TRIP]};

   // Write decodes
   assign wr_pll_en     = reg_write & hit(reg_addr, `PLAI_OFS_PLL_IRQ_EN);
   assign wr_align_en   = reg_write & hit(reg_addr, `PLAI_OFS_ALIGN_IRQ_EN);
   assign wr_pll_stat   = reg_write & hit(reg_addr, `PLAI_OFS_PLL_STATUS);
   assign wr_align_stat = reg_write & hit(reg_addr, `PLAI_OFS_ALIGN_STATUS);

   // Write-one-to-clear strobes; bit 5 of 0x023 has no target
   // A zero in the written byte leaves the matching latched bit alone
   assign clr_vec = {wr_pll_stat & reg_wdata[`PLAI_BIT_CONV_UNLOCK],
                     wr_pll_stat & reg_wdata[`PLAI_BIT_CONV_LOCKED],
                     wr_pll_stat & reg_wdata[`PLAI_BIT_SERIAL_UNLOCK],
                     wr_pll_stat & reg_wdata[`PLAI_BIT_SERIAL_LOCKED],
                     wr_align_stat & reg_wdata[`PLAI_BIT_ALIGN_ROTATE],
                     wr_align_stat & reg_wdata[`PLAI_BIT_ALIGN_WINDOW],
                     wr_align_stat & reg_wdata[`PLAI_BIT_ALIGN_TRIP]};

   // Edge seen on the synchronised level only, never on the first stage
   assign rise = sync_b & ~live_d;

   // Sticky or live per enable
   // PLL flags follow the same per-bit law
   assign next_stat = stat_update(stat, en_vec, en_d, sync_b, rise,
                                  clr_vec);

   // Status bytes as software sees them; bit 5 and others read zero
   assign pll_status_byte = {stat[6], stat[5], 1'b0, stat[4], stat[3],
                             3'b000};
   assign align_status_byte = {5'b00000, stat[2], stat[1], stat[0]};

   // Two-stage synchronisers; the lock detectors run off other clocks
   // live_d is a third stage used only to find rising edges
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_a <= `PLAI_RST_EVENTS;
         sync_b <= `PLAI_RST_EVENTS;
         live_d <= `PLAI_RST_EVENTS;
      end else begin
         sync_a <= ev_raw;
         sync_b <= sync_a;
         live_d <= sync_b;
      end
   end

   // Enable registers; reserved 6:5 of 0x021 never written
   // Unused enable bits stay as plain storage so software reads back
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pll_irq_enable   <= `PLAI_RST_BYTE;
         align_irq_enable <= `PLAI_RST_BYTE;
      end else begin
         if (wr_pll_en) begin
            pll_irq_enable <= reg_wdata & `PLAI_PLL_EN_RW_MASK;
         end
         if (wr_align_en) begin
            align_irq_enable <= reg_wdata & `PLAI_ALIGN_EN_RW_MASK;
         end
      end
   end

   // Status flops, plus last cycle's enables for the sticky hold term
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         stat <= `PLAI_RST_EVENTS;
         en_d <= `PLAI_RST_EVENTS;
      end else begin
         stat <= next_stat;
         en_d <= en_vec;
      end
   end

   // Enabled bits that will be latched after this edge; any of them
   // holds the shared interrupt line low
   assign irq_src = next_stat & en_vec;

   // Interrupt output, registered to keep it glitch-free on the pin.
   // Other status registers combine with this line outside the slice;
   // it is released high only when nothing here is latched.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~|irq_src;
      end
   end

   // Read port: one-cycle answer, unmapped addresses read zero
   // Read data holds between reads, so a late sample still sees it
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata  <= `PLAI_RST_BYTE;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            case (reg_addr)
               `PLAI_OFS_PLL_IRQ_EN:   reg_rdata <= pll_irq_enable;
               `PLAI_OFS_ALIGN_IRQ_EN: reg_rdata <= align_irq_enable;
               `PLAI_OFS_PLL_STATUS:   reg_rdata <= pll_status_byte;
               `PLAI_OFS_ALIGN_STATUS: reg_rdata <= align_status_byte;
               default:                reg_rdata <= `PLAI_RST_BYTE;
            endcase
         end
      end
   end

endmodule // plai_irq_status

// ===== tb/plai_irq_status_properties.sv
// Port assertions for the PLL and alignment interrupt slice
`timescale 1ns/1ps
`include "plai_map.vh"
module plai_props (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        conv_pll_unlock_in,
   input wire logic        conv_pll_locked_in,
   input wire logic        serial_pll_unlock_in,
   input wire logic        serial_pll_locked_in,
   input wire logic        align_rotate_in,
   input wire logic        align_window_in,
   input wire logic        align_trip_in,
   input wire logic        irq_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Any event pin; pin to irq takes two sync edges and the status flop
   wire any_ev = conv_pll_unlock_in | conv_pll_locked_in |
      serial_pll_unlock_in | serial_pll_locked_in | align_rotate_in |
      align_window_in | align_trip_in;
   sequence rd_at(a);
      reg_read && reg_addr == a;
   endsequence
   AST_READ_ANSWERED:
      assert property (reg_read |=> reg_rvalid) else $error("read unanswered");
   AST_NO_STRAY_VALID:
      assert property (!reg_read |=> !reg_rvalid) else $error("stray valid");
   AST_STATUS_RSV_ZERO:
      assert property (rd_at(`PLAI_OFS_PLL_STATUS) |=>
         reg_rdata[5] == 1'b0 && reg_rdata[2:0] == 3'h0)
         else $error("status reserved bits set");
   AST_ENABLE_RSV_ZERO:
      assert property (rd_at(`PLAI_OFS_ALIGN_IRQ_EN) |=>
         reg_rdata[6:5] == 2'h0) else $error("enable bits 6:5 set");
   AST_ALIGN_STATUS_RSV:
      assert property (rd_at(`PLAI_OFS_ALIGN_STATUS) |=>
         reg_rdata[7:3] == 5'h00) else $error("alignment status upper set");
   AST_IRQ_STICKY:
      assert property (!irq_n && !reg_write |=> !irq_n)
         else $error("irq released without a write");
   AST_IRQ_CAUSE:
      assert property ($fell(irq_n) |-> $past(any_ev, 3))
         else $error("irq without synced event");
   AST_RESET_IDLE:
      assert property ($fell(reset) |-> irq_n && !reg_rvalid)
         else $error("outputs busy after reset");
endmodule // plai_props
bind plai_irq_status plai_props i_props (.clk(clk), .reset(reset),
   .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .conv_pll_unlock_in(conv_pll_unlock_in),
   .conv_pll_locked_in(conv_pll_locked_in),
   .serial_pll_unlock_in(serial_pll_unlock_in),
   .serial_pll_locked_in(serial_pll_locked_in),
   .align_rotate_in(align_rotate_in), .align_window_in(align_window_in),
   .align_trip_in(align_trip_in), .irq_n(irq_n));

// ===== tb/tb_top.sv
// Self-checking bench for the PLL and alignment interrupt slice
`timescale 1ns/1ps
`include "plai_map.vh"
module tb_top;
   logic        clk = 0, reset = 1, reg_write = 0, reg_read = 0;
   logic [11:0] reg_addr = 0, sa, ea;
   logic [7:0]  reg_wdata = 0, reg_rdata, d, m, want;
   logic        reg_rvalid, irq_n;
   logic [6:0]  ev = 0;
   logic [7:0]  exp_q[$];
   int          error_cnt = 0, checks = 0, i;
   int          pos[7] = '{7, 6, 4, 3, 2, 1, 0};
   plai_irq_status i_dut (.clk(clk), .reset(reset), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .conv_pll_unlock_in(ev[6]), .conv_pll_locked_in(ev[5]),
      .serial_pll_unlock_in(ev[4]), .serial_pll_locked_in(ev[3]),
      .align_rotate_in(ev[2]), .align_window_in(ev[1]),
      .align_trip_in(ev[0]), .irq_n(irq_n));
   // 50 ns clock
   always #25 clk = ~clk;
   task automatic chk(input logic [7:0] seen, exp, input string nm);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Inputs move 2 ns after the edge so sampling never races
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // One-cycle strobe; a read queues its expected byte
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [7:0] v);
      if (!w) exp_q.push_back(v);
      tick(1);
      reg_write = w;
      reg_read = !w;
      reg_addr = a;
      reg_wdata = v;
      tick(1);
      reg_write = 0;
      reg_read = 0;
   endtask
   task automatic complete_run;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Each read answer is matched against the oldest queued byte
   always @(posedge clk)
      if (reg_rvalid === 1'b1) begin
         chk({7'h00, exp_q.size() > 0}, 8'h01, "read queued");
         want = exp_q.size() ? exp_q.pop_front() : 8'h00;
         chk(reg_rdata, want, "read data");
      end
   initial begin
      void'($urandom(32'h5B17));
      tick(4);
      reset = 0;
      acc(0, `PLAI_OFS_PLL_STATUS, 8'h00);
      acc(0, `PLAI_OFS_ALIGN_IRQ_EN, 8'h00);
      acc(1, `PLAI_OFS_ALIGN_IRQ_EN, 8'hFF);
      acc(0, `PLAI_OFS_ALIGN_IRQ_EN, 8'h9F);
      d = $urandom;
      acc(1, `PLAI_OFS_PLL_IRQ_EN, d);
      acc(0, `PLAI_OFS_PLL_IRQ_EN, d);
      acc(1, `PLAI_OFS_PLL_STATUS, 8'hFF);
      acc(0, `PLAI_OFS_PLL_STATUS, 8'h00);
      acc(0, 12'h0FF, 8'h00);
      // Each event live with enable off, then latched with it on
      for (i = 0; i < 7; i++) begin
         sa = i < 4 ? `PLAI_OFS_PLL_STATUS : `PLAI_OFS_ALIGN_STATUS;
         ea = i < 4 ? `PLAI_OFS_PLL_IRQ_EN : `PLAI_OFS_ALIGN_IRQ_EN;
         m = 8'h01 << pos[i];
         acc(1, ea, 8'h00);
         ev[6-i] = 1;
         tick(4);
         acc(0, sa, m);
         chk({7'h00, irq_n}, 8'h01, "irq live");
         ev[6-i] = 0;
         tick(4);
         acc(1, ea, m);
         ev[6-i] = 1;
         tick(1);
         ev[6-i] = 0;
         tick(4);
         chk({7'h00, irq_n}, 8'h00, "irq latched");
         acc(1, sa, ~m);
         acc(0, sa, m);
         acc(1, sa, m);
         chk({7'h00, irq_n}, 8'h01, "irq cleared");
         acc(0, sa, 8'h00);
      end
      // Two latched events: irq holds until both are cleared
      acc(1, `PLAI_OFS_ALIGN_IRQ_EN, 8'h03);
      ev[1:0] = 2'h3;
      tick(1);
      ev[1:0] = 2'h0;
      tick(4);
      acc(1, `PLAI_OFS_ALIGN_STATUS, 8'h01);
      chk({7'h00, irq_n}, 8'h00, "irq one left");
      acc(1, `PLAI_OFS_ALIGN_STATUS, 8'h02);
      chk({7'h00, irq_n}, 8'h01, "irq all clear");
      // Enable turned on over a level already high must not latch it
      ev[6] = 1;
      tick(4);
      acc(1, `PLAI_OFS_PLL_IRQ_EN, 8'h80);
      tick(2);
      chk({7'h00, irq_n}, 8'h01, "irq no rise");
      acc(0, `PLAI_OFS_PLL_STATUS, 8'h00);
      ev[6] = 0;
      // Mid-run reset returns every written enable to zero
      acc(1, `PLAI_OFS_ALIGN_IRQ_EN, 8'h07);
      reset = 1;
      tick(2);
      reset = 0;
      acc(0, `PLAI_OFS_ALIGN_IRQ_EN, 8'h00);
      acc(0, `PLAI_OFS_PLL_IRQ_EN, 8'h00);
      for (i = 0; i < 10 && exp_q.size() > 0; i++) tick(1);
      if (exp_q.size() > 0) error_cnt++;
      complete_run();
   end
endmodule // tb_top
